/* File: verilog/adc_internal_sck_serial_readout.sv */
// Purpose: Result readout with self-generated serial clock, single-cycle and continuous
// Assumes: cs_b_i, sdi_i and pin levels are asynchronous; result_i from core logic
// Notes:   Conversion length scales with oversample ratio; shorten for simulation
// Overview of operation
// - Data output floats whenever chip select is high.
// - Chip select low in single-cycle mode drives clock low and shows done status on data output.
// - Busy high while converting, low at end, low until result read.
// - Done status with chip select low leaves sleep; raising select keeps sleep.
// - Clock rises 500 ns after select falls or done status falls.
// - Select rising before the test delay keeps sleep and held result.
// - Frame spans 32 rising clock edges; data changes on falling edges.
// - Single-cycle frame end drives data high, clock high, starts conversion.
// - Select rising mid-frame in single-cycle mode aborts the frame and starts a conversion.
// - Abort before the 14th falling clock edge discards input and keeps settings.
// - Continuous mode: clock, data, busy high converting, all low at end.
// - Continuous mode sleeps at least 500 ns then starts the frame itself.
// - Continuous frame end drives data high, clock high through conversion.
// - Oversample ratio is a power of two from 64 to 32768.
// - Grounded oscillator pin selects the on-chip 1.8 MHz sample rate.
// - Output rate is one eighth of the first null frequency.
// - External oscillator divided by five sets the sample rate.
// - Input held high selects oversample ratio 32768.
// - Busy rises when the data cycle ends, marking a new conversion.
`timescale 1ns/1ns
module adc_internal_sck_serial_readout
  import sar_readout_pkg::*;
#(
  parameter int RESULT_W    = 31,
  parameter int SHORTEN_LOG = 0
) (
  // Clock, reset and unused guard input
  input  wire logic                cs_b_i_unused_guard,
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // Pins
  input  wire logic                cs_b_i,
  input  wire logic                sdi_i,
  input  wire logic                clock_source_select_i,
  input  wire logic                oscillator_pin_i,
  input  wire logic                continuous_mode_i,
  output logic                     sck_o,
  output logic                     sdo_o,
  output logic                     sdo_oe_b_o,
  output logic                     busy_o,
  // Converter core
  input  wire logic [RESULT_W-1:0] result_i,
  output logic [12:0]              config_word_o,
  output logic [15:0]              oversample_ratio_o,
  output logic                     ext_osc_o
);
  state_t      state;
  logic [2:0]  cs_s;
  logic [1:0]  sdi_s;
  logic [1:0]  sel_s;
  logic [1:0]  cont_s;
  logic [2:0]  osc_s;
  logic [7:0]  osc_idle;
  logic [2:0]  ext_cnt;
  logic [3:0]  int_cnt;
  logic        sample_tick;
  logic [18:0] conv_cnt;
  logic [3:0]  test_cnt;
  logic [3:0]  half_cnt;
  logic [5:0]  rise_cnt;
  logic [5:0]  fall_cnt;
  logic [FRAME_BITS-1:0] sreg;
  logic [CFG_BITS-1:0]   in_sreg;
  logic [3:0]  osr_log;
  logic        cs_b;
  logic        cs_rise;
  logic        cs_fall;
  logic        cont;
  logic        half_done;
  logic        conv_done;
  logic        abort;
  logic        commit;
  logic [3:0]  next_osr_log;

  function automatic logic [18:0] conv_len(input logic [3:0] lg);
    // Shift amount kept at five bits; four would wrap at the top ratio
    conv_len = (19'h00001 << (5'(lg) + 5'(NULL_TO_RATE_LOG))) >> SHORTEN_LOG;
  endfunction

  function automatic logic [3:0] osr_log_of(input logic [CFG_OSR_W-1:0] code);
    if (code > 4'(OSR_CODE_MAX)) begin
      osr_log_of = 4'(OSR_MAX_LOG);
    end else begin
      osr_log_of = code + 4'(OSR_MIN_LOG);
    end
  endfunction

  // Two-stage synchronisers; third stage on cs_s here and on osc_s below, for edge detect
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s   <= 3'h7;
      sdi_s  <= 2'h0;
      sel_s  <= 2'h0;
      cont_s <= 2'h0;
    end else begin
      cs_s   <= {cs_s[1:0], cs_b_i};
      sdi_s  <= {sdi_s[0], sdi_i};
      sel_s  <= {sel_s[0], clock_source_select_i};
      cont_s <= {cont_s[0], continuous_mode_i};
    end
  end

  assign cs_b    = cs_s[1];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign cs_fall = ~cs_s[1] & cs_s[2];
  assign cont    = cont_s[1];

  // Sample clock: external pin activity wins, otherwise internal divider
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_s       <= 3'h0;
      osc_idle    <= 8'(OSC_IDLE_CYC);
      ext_cnt     <= 3'h0;
      int_cnt     <= 4'h0;
      sample_tick <= 1'b0;
      ext_osc_o   <= 1'b0;
    end else begin
      osc_s <= {osc_s[1:0], oscillator_pin_i};
      if (osc_s[1] & ~osc_s[2]) begin
        osc_idle <= 8'h00;
        ext_cnt  <= (ext_cnt == 3'(EXT_OSC_DIV - 1)) ? 3'h0 : ext_cnt + 3'h1;
      end else if (osc_idle != 8'(OSC_IDLE_CYC)) begin
        osc_idle <= osc_idle + 8'h01;
      end
      int_cnt   <= (int_cnt == 4'(INT_OSC_DIV - 1)) ? 4'h0 : int_cnt + 4'h1;
      ext_osc_o <= (osc_idle != 8'(OSC_IDLE_CYC));
      if (osc_idle != 8'(OSC_IDLE_CYC)) begin
        sample_tick <= (osc_s[1] & ~osc_s[2]) && (ext_cnt == 3'(EXT_OSC_DIV - 1));
      end else begin
        sample_tick <= (int_cnt == 4'(INT_OSC_DIV - 1));
      end
    end
  end

  assign half_done = (half_cnt == 4'(SCK_HALF_CYC - 1));
  assign conv_done = (state == ST_CONV) && sample_tick &&
                     (conv_cnt == conv_len(osr_log) - 19'h00001);
  assign abort     = (state == ST_SHIFT) && cs_rise && !cont;
  // Store only after the 14th falling edge; earlier aborts drop the word
  assign commit    = (state == ST_SHIFT) && !abort && half_done && sck_o &&
                     (rise_cnt != 6'(FRAME_BITS)) &&
                     (fall_cnt == 6'(CFG_COMMIT_FALL - 1));

  // Conversion, sleep and frame sequencing
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state      <= ST_CONV;
      conv_cnt   <= 19'h00000;
      test_cnt   <= 4'h0;
      half_cnt   <= 4'h0;
      rise_cnt   <= 6'h00;
      fall_cnt   <= 6'h00;
      sreg       <= '0;
      in_sreg    <= '0;
      sck_o      <= 1'b1;
      sdo_o      <= 1'b1;
      sdo_oe_b_o <= 1'b1;
      busy_o     <= 1'b1;
    end else begin
      sdo_oe_b_o <= cs_b;
      case (state)
        ST_CONV: begin
          if (cs_fall && !cont) begin
            sck_o <= 1'b0;
          end
          if (conv_done) begin
            state    <= ST_SLEEP;
            conv_cnt <= 19'h00000;
            test_cnt <= 4'h0;
            sreg     <= {1'b0, result_i};
            busy_o   <= 1'b0;
            sck_o    <= 1'b0;
            sdo_o    <= 1'b0;
          end else if (sample_tick) begin
            conv_cnt <= conv_cnt + 19'h00001;
          end
        end
        ST_SLEEP: begin
          sck_o <= 1'b0;
          sdo_o <= 1'b0;
          if (cs_b || !sel_s[1]) begin
            test_cnt <= 4'h0;
          end else if (test_cnt == 4'(STATUS_TEST_CYC - 1)) begin
            state    <= ST_SHIFT;
            sck_o    <= 1'b1;
            half_cnt <= 4'h0;
            rise_cnt <= 6'h01;
            fall_cnt <= 6'h00;
            in_sreg  <= {in_sreg[CFG_BITS-2:0], sdi_s[1]};
          end else begin
            test_cnt <= test_cnt + 4'h1;
          end
        end
        ST_SHIFT: begin
          half_cnt <= half_done ? 4'h0 : half_cnt + 4'h1;
          if (abort) begin
            state  <= ST_CONV;
            busy_o <= 1'b1;
            sdo_o  <= 1'b1;
            sck_o  <= 1'b1;
          end else if (half_done && sck_o && rise_cnt == 6'(FRAME_BITS)) begin
            state  <= ST_CONV;
            busy_o <= 1'b1;
            sdo_o  <= 1'b1;
          end else if (half_done && sck_o) begin
            sck_o    <= 1'b0;
            sreg     <= {sreg[FRAME_BITS-2:0], 1'b0};
            sdo_o    <= sreg[FRAME_BITS-2];
            fall_cnt <= fall_cnt + 6'h01;
          end else if (half_done) begin
            sck_o    <= 1'b1;
            rise_cnt <= rise_cnt + 6'h01;
            if (rise_cnt < 6'(CFG_BITS)) begin
              in_sreg <= {in_sreg[CFG_BITS-2:0], sdi_s[1]};
            end
          end
        end
        default: begin
          state <= ST_CONV;
        end
      endcase
    end
  end

  assign next_osr_log = osr_log_of(in_sreg[CFG_OSR_LSB +: CFG_OSR_W]);

  // Settings update only on a complete input word
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      config_word_o      <= CFG_RST;
      osr_log            <= OSR_LOG_RST;
      oversample_ratio_o <= OSR_RST;
    end else begin
      if (commit) begin
        config_word_o <= in_sreg;
        osr_log       <= next_osr_log;
      end
      oversample_ratio_o <= 16'h0001 << osr_log;
    end
  end

  localparam int TEST_LAST = STATUS_TEST_CYC - 1;

  sequence s_sleep_armed;
    (state == ST_SLEEP) && !cs_b && sel_s[1];
  endsequence

  AST_SDO_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cs_b |=> sdo_oe_b_o)
    else $error("data output not floated with select high");

  AST_BUSY_SLEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(busy_o) |-> (state == ST_SLEEP) && !sdo_o)
    else $error("busy fell outside sleep entry");

  AST_TEST_DELAY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_sleep_armed ##0 (test_cnt == 4'(TEST_LAST)) |=> sck_o && (state == ST_SHIFT))
    else $error("clock did not rise after status test delay");

  AST_SLEEP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state == ST_SLEEP) && cs_b |=> (state == ST_SLEEP) && $stable(sreg))
    else $error("sleep left with select high");

  AST_HALF_PERIOD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(sck_o) && (state == ST_SHIFT) |-> sck_o [*5])
    else $error("serial clock high phase too short");

  AST_FRAME_END: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(busy_o) |-> sck_o && sdo_o && (state == ST_CONV))
    else $error("frame end did not leave clock and data high");

  AST_ABORT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    abort |=> (state == ST_CONV) && busy_o)
    else $error("abort did not start a conversion");

  AST_COMMIT_LATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $changed(config_word_o) |-> $past(fall_cnt) == 6'(CFG_COMMIT_FALL - 1))
    else $error("input word stored before the 14th falling edge");

  AST_CONT_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cont && $fell(busy_o) |-> !sck_o && !sdo_o)
    else $error("continuous mode end of conversion not all low");

  AST_OSR_POW2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $onehot(oversample_ratio_o) && (oversample_ratio_o >= 16'h0040))
    else $error("oversample ratio out of range");
endmodule

/* File: verilog/sar_readout_pkg.sv */
// Purpose: Shared constants and state type for the internal-clock serial readout
// Assumes: 20 MHz system clock
// Notes:   Status test delay kept in ns, its cycle count derived from it
package sar_readout_pkg;
  localparam int CLK_PERIOD_NS        = 50;
  localparam int STATUS_TEST_DELAY_NS = 500;
  // Least time, rounded up
  localparam int STATUS_TEST_CYC      =
    (STATUS_TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC         = 5;
  localparam int FRAME_BITS           = 32;
  localparam int CFG_BITS             = 13;
  localparam int CFG_COMMIT_FALL      = 14;
  localparam int EXT_OSC_DIV          = 5;
  localparam int CLK_KHZ              = 20000;
  localparam int INT_OSC_KHZ          = 1800;
  localparam int INT_OSC_DIV          = CLK_KHZ / INT_OSC_KHZ;
  localparam int OSC_IDLE_CYC         = 64;
  // Conversion spans eight null periods
  localparam int NULL_TO_RATE_LOG     = 3;
  localparam int OSR_MIN_LOG          = 6;
  localparam int OSR_MAX_LOG          = 15;
  localparam int OSR_CODE_MAX         = OSR_MAX_LOG - OSR_MIN_LOG;
  localparam int CFG_OSR_LSB          = 9;
  localparam int CFG_OSR_W            = 4;
  localparam logic [3:0]  OSR_LOG_RST = 4'hf;
  localparam logic [15:0] OSR_RST     = 16'h8000;
  localparam logic [12:0] CFG_RST     = 13'h0000;

  typedef enum logic [1:0] {
    ST_CONV  = 2'b00,
    ST_SLEEP = 2'b01,
    ST_SHIFT = 2'b10
  } state_t;
endpackage

/* File: testbench/serial_result_receiver.sv */
// Purpose: Controller model capturing frames sent on the generated serial clock
// Assumes: Device pins sampled on the system clock
// Notes:   Config bits go out MSB first, all later bits are ones
`timescale 1ns/1ns
module serial_result_receiver (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Device pins
  input  wire logic        sck_i,
  input  wire logic        sdo_i,
  input  wire logic        sdo_oe_b_i,
  input  wire logic        cs_b_i,
  output logic             sdi_o,
  // Bench side
  input  wire logic [12:0] cfg_i,
  output logic [31:0]      word_o,
  output logic [5:0]       rises_o,
  output logic             done_o
);
  logic sck_q;
  wire  rise = sck_i && !sck_q && !sdo_oe_b_i;
  assign sdi_o = (rises_o < 6'd13) ? cfg_i[4'd12 - rises_o[3:0]] : 1'b1;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q   <= 1'b1;
      word_o  <= '0;
      rises_o <= '0;
      done_o  <= 1'b0;
    end else begin
      sck_q  <= sck_i;
      done_o <= rise && (rises_o == 6'd31);
      if (rise) begin
        word_o  <= {word_o[30:0], sdo_i};
        rises_o <= (rises_o == 6'd31) ? 6'd0 : rises_o + 6'd1;
      end else if (cs_b_i) begin
        rises_o <= '0;
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the internal-clock serial readout
// Assumes: 20 MHz clock, conversion shortened by SHORTEN_LOG
// Notes:   Frames checked from a queue of expected words
`timescale 1ns/1ns
module tb_top;
  import sar_readout_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cs_b_i = 1'b1;
  logic        osc = 1'b0;
  logic        cont = 1'b0;
  logic [30:0] result = '0;
  logic [12:0] cfg = '0;
  logic        sdi, sck, sdo, sdo_oe_b, busy, ext_osc, rx_done;
  logic [12:0] config_word;
  logic [15:0] ratio;
  logic [31:0] rx_word;
  logic [5:0]  rx_rises;
  logic [31:0] expq[$];
  int          errors = 0;
  int          samples_checked = 0;
  int          n;

  always #25 clk_i = ~clk_i;

  adc_internal_sck_serial_readout #(.RESULT_W(31), .SHORTEN_LOG(9)) adc_internal_sck_serial_readout_i (
    .cs_b_i_unused_guard(1'b0), .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
    .sdi_i(sdi), .clock_source_select_i(1'b1), .oscillator_pin_i(osc),
    .continuous_mode_i(cont), .sck_o(sck), .sdo_o(sdo), .sdo_oe_b_o(sdo_oe_b),
    .busy_o(busy), .result_i(result), .config_word_o(config_word),
    .oversample_ratio_o(ratio), .ext_osc_o(ext_osc));

  serial_result_receiver serial_result_receiver_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .sdo_i(sdo), .sdo_oe_b_i(sdo_oe_b),
    .cs_b_i(cs_b_i), .sdi_o(sdi), .cfg_i(cfg), .word_o(rx_word), .rises_o(rx_rises),
    .done_o(rx_done));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_busy(input logic v, input int lim);
    int k;
    k = 0;
    while (busy !== v && k < lim) begin
      @(negedge clk_i);
      k++;
    end
    chk(32'(busy), 32'(v));
  endtask

  task automatic frame(input logic [12:0] c);
    cfg = c;
    wait_busy(1'b0, 8000);
    cs_b_i = 1'b0;
    expq.push_back({1'b0, result});
    repeat (5) @(negedge clk_i);
    chk({sck, sdo}, 32'h0);
    n = 5;
    while (sck !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'(n >= 10 && n <= 15), 32'h1);
    wait_busy(1'b1, 400);
    chk({sck, sdo}, 32'h3);
    cs_b_i = 1'b1;
    // New value for the conversion just started; latched at its end
    result = 31'($urandom);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Oldest expected word against each captured frame
  always @(negedge clk_i) begin
    if (rx_done === 1'b1) begin
      if (expq.size() == 0) chk(rx_word, 32'hffffffff);
      else chk(rx_word, expq.pop_front());
    end
  end

  initial begin
    // Generous bound on all tests
    #(20000 * 50);
    errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h4ce9b9b3));
    result = 31'($urandom);
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(32'(sdo_oe_b), 32'h1);
    // Status probe during the first conversion
    cs_b_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk({sck, sdo, sdo_oe_b, busy}, 32'h5);
    cs_b_i = 1'b1;
    frame(13'h0000);
    chk(ratio, 32'h40);
    $display("test full frame done");
    cfg = 13'h0600;
    wait_busy(1'b0, 200);
    cs_b_i = 1'b0;
    n = 0;
    while (rx_rises !== 6'd5 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'(rx_rises), 32'h5);
    cs_b_i = 1'b1;
    wait_busy(1'b1, 8);
    chk(ratio, 32'h40);
    chk(32'(config_word), 32'h0);
    $display("test abort done");
    wait_busy(1'b0, 200);
    cs_b_i = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_b_i = 1'b1;
    repeat (20) @(negedge clk_i);
    chk({busy, rx_rises}, 32'h0);
    frame(13'h0600);
    chk(ratio, 32'h200);
    chk(32'(config_word), 32'h600);
    $display("test sleep kept done");
    repeat (40) begin
      @(negedge clk_i);
      osc = ~osc;
    end
    chk(32'(ext_osc), 32'h1);
    osc = 1'b0;
    repeat (100) @(negedge clk_i);
    chk(32'(ext_osc), 32'h0);
    $display("test oscillator done");
    cfg = 13'h1fff;
    cont = 1'b1;
    cs_b_i = 1'b0;
    expq.push_back({1'b0, result});
    wait_busy(1'b1, 600);
    chk(32'(sck), 32'h1);
    result = 31'($urandom);
    wait_busy(1'b0, 8000);
    chk({busy, sck, sdo}, 32'h0);
    expq.push_back({1'b0, result});
    wait_busy(1'b1, 600);
    chk(ratio, 32'h8000);
    chk(32'(config_word), 32'h1fff);
    chk(expq.size(), 32'h0);
    $display("test continuous done");
    test_done();
  end
endmodule
